// File: rsc_defines.svh
// constants for the reset source control block
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

`define RSC_ADDR_SUPPLY   8'hFF
`define RSC_ADDR_CAUSE    8'hEF

`define RSC_BIT_MON_EN    7
`define RSC_BIT_STATUS    6
`define RSC_BIT_LEVEL     5

`define RSC_BIT_FLASH     6
`define RSC_BIT_COMP      5
`define RSC_BIT_SOFT      4
`define RSC_BIT_WDT       3
`define RSC_BIT_MCD       2
`define RSC_BIT_POR       1
`define RSC_BIT_PIN       0

`define RSC_FLAGS_POR     7'h02
`define RSC_FLASH_RESERVED 16'hF800
`define RSC_WD_DIV_LAST   4'hB
`define RSC_WD_LIMIT      8'hFF

`endif

// File: rsc_pkg.sv
// types shared by the reset source control block
package rsc_pkg;
  typedef enum logic [0:0]
  {
    RSC_RUN  = 1'b0,
    RSC_HOLD = 1'b1
  } rsc_state_t;

  typedef logic [6:0] rsc_cause_t;
endpackage : rsc_pkg

// File: rsc_watchdog.sv
// watchdog counter clocked by system clock divided by twelve
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defines.svh"
module rsc_watchdog
  import rsc_pkg::*;
(
  input  wire logic mclk,      // system clock
  input  wire logic rst,       // any reset, sync high
  input  wire logic kick,      // service pulse
  input  wire logic disable_n, // low disables counting
  output var  logic overflow   // one-cycle timeout pulse
);
  logic [3:0] prescale;
  logic [7:0] count;
  logic       enabled;
  wire        tick = (prescale == `RSC_WD_DIV_LAST);
  wire        atLimit = (count == `RSC_WD_LIMIT);

  // enabled at reset, ticks every twelfth clock
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prescale <= 4'h0;
      count    <= 8'h00;
      enabled  <= 1'b1;
      overflow <= 1'b0;
    end
    else
    begin
      enabled  <= enabled & disable_n;
      prescale <= tick ? 4'h0 : prescale + 4'h1;
      overflow <= enabled & disable_n & tick & atLimit & ~kick;
      if (kick || !enabled)
        count <= 8'h00;
      else if (tick)
        count <= count + 8'h01;
    end
  end
endmodule : rsc_watchdog
`default_nettype wire

// File: reset_source_control.sv
// reset source control: cause register, supply monitor control, reset sequencing
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defines.svh"
module reset_source_control
  import rsc_pkg::*;
(
  input  wire logic        mclk,            // system clock, 125 MHz
  input  wire logic        rst,             // power-on reset, sync high
  input  wire logic [7:0]  sfrAddr,         // register address
  input  wire logic        sfrWe,           // register write strobe
  input  wire logic        sfrRe,           // register read strobe
  input  wire logic [7:0]  sfrWdata,        // write data
  output var  logic [7:0]  sfrRdata,        // read data, one cycle later
  input  wire logic        rstPinIn,        // reset pin level, low resets
  output var  logic        rstPinOut,       // reset pin drive value
  output var  logic        rstPinOeN,       // pin drive enable, low drives
  input  wire logic        supplyAbove,     // monitor output, 1 above threshold
  output var  logic        monitorOn,       // monitor circuit power
  output var  logic        thresholdHigh,   // selected trip level
  input  wire logic        clkStuck,        // clock-loss one-shot expired
  input  wire logic        compAbove,       // comparator out, 1 plus above minus
  input  wire logic        wdKick,          // watchdog service pulse
  input  wire logic        wdRunN,          // low disables watchdog
  input  wire logic        flashWriteErase, // write/erase with store write enabled
  input  wire logic        flashCodeRead,   // code-space data read
  input  wire logic        flashBranch,     // program fetch after branch
  input  wire logic [15:0] flashAddr,       // target flash address
  input  wire logic        flashSecBlocked, // access refused by security
  output var  logic        sysReset         // system reset, high in reset
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rsc_state_t state;
  rsc_cause_t pending;
  rsc_cause_t flags;
  logic       monEnable;
  logic       monSelect;
  logic       level;
  logic       mcdEnable;
  logic       compEnable;
  logic       wdOverflow;

  function automatic logic addrHit(input logic [7:0] a, input logic [7:0] t);
    addrHit = (a == t);
  endfunction : addrHit

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire running     = (state == RSC_RUN);
  wire supplyWrite = sfrWe & running & addrHit(sfrAddr, `RSC_ADDR_SUPPLY);
  wire causeWrite  = sfrWe & running & addrHit(sfrAddr, `RSC_ADDR_CAUSE);
  wire supplyRead  = sfrRe & addrHit(sfrAddr, `RSC_ADDR_SUPPLY);
  wire causeRead   = sfrRe & addrHit(sfrAddr, `RSC_ADDR_CAUSE);

  wire [7:0] supplyView = {monEnable, supplyAbove, level, 5'h00};
  wire [7:0] causeView  = {1'b0, flags};
  wire [7:0] next_rdata = supplyRead ? supplyView : (causeRead ? causeView : 8'h00);

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  // pin low resets; our own drive of the pin is no request
  wire pinSrc    = ~rstPinIn & rstPinOeN;
  // monitor resets only when enabled and selected
  wire supplySrc = monEnable & monSelect & ~supplyAbove;
  wire mcdSrc    = mcdEnable & clkStuck;
  // comparator reset when plus below minus
  wire compSrc   = compEnable & ~compAbove;
  // soft reset on write of one
  wire softSrc   = causeWrite & sfrWdata[`RSC_BIT_SOFT];

  wire flashAny      = flashWriteErase | flashCodeRead | flashBranch;
  wire flashReserved = (flashAddr >= `RSC_FLASH_RESERVED);
  wire flashIllegal  = flashAny & (flashReserved | flashSecBlocked);
  wire flashGuarded  = level & monEnable & monSelect;
  wire flashSupply   = (flashWriteErase | flashCodeRead) & ~flashGuarded;
  wire flashSrc      = running & (flashIllegal | flashSupply);

  wire [6:0] srcVec = {flashSrc, compSrc, softSrc, wdOverflow, mcdSrc, supplySrc, pinSrc};
  wire       anySrc = |srcVec;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // causes accumulate while held
  wire       next_hold    = anySrc | (~running & anySrc);
  wire [6:0] next_pending = running ? srcVec : (pending | srcVec);
  // pin driven only for power/supply resets
  wire       next_pinDrive = next_hold & next_pending[`RSC_BIT_POR];
  wire       next_level    = (running && anySrc) ? 1'b0 :
                             (supplyWrite ? sfrWdata[`RSC_BIT_LEVEL] : level);

  rsc_watchdog u_watchdog
  (
    .mclk      (mclk),
    .rst       (rst | sysReset),
    .kick      (wdKick),
    .disable_n (wdRunN),
    .overflow  (wdOverflow)
  );

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state     <= RSC_HOLD;
      pending   <= `RSC_FLAGS_POR;
      sysReset  <= 1'b1;
      rstPinOeN <= 1'b0;
    end
    else
    begin
      state     <= next_hold ? RSC_HOLD : RSC_RUN;
      pending   <= next_pending;
      sysReset  <= next_hold;
      rstPinOeN <= ~next_pinDrive;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      flags <= `RSC_FLAGS_POR;
    else if (!running && !anySrc)
      flags <= pending;
  end

  // monitor enable changed by power-on or software only
  always_ff @(posedge mclk)
  begin
    if (rst)
      monEnable <= 1'b1;
    else if (supplyWrite)
      monEnable <= sfrWdata[`RSC_BIT_MON_EN];
  end

  always_ff @(posedge mclk)
  begin
    if (rst || (running && anySrc))
    begin
      level      <= 1'b0;
      mcdEnable  <= 1'b0;
      compEnable <= 1'b0;
    end
    else if (supplyWrite)
      level <= sfrWdata[`RSC_BIT_LEVEL];
    else if (causeWrite)
    begin
      mcdEnable  <= sfrWdata[`RSC_BIT_MCD];
      compEnable <= sfrWdata[`RSC_BIT_COMP];
    end
  end

  // monitor selection survives non-power resets
  always_ff @(posedge mclk)
  begin
    if (rst)
      monSelect <= 1'b1;
    else if (causeWrite)
      monSelect <= sfrWdata[`RSC_BIT_POR];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sfrRdata      <= 8'h00;
      rstPinOut     <= 1'b0;
      monitorOn     <= 1'b1;
      thresholdHigh <= 1'b0;
    end
    else
    begin
      sfrRdata      <= next_rdata;
      rstPinOut     <= 1'b0;
      monitorOn     <= supplyWrite ? sfrWdata[`RSC_BIT_MON_EN] : monEnable;
      thresholdHigh <= next_level;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
    supplyRead |=> sfrRdata[4:0] == 5'h00)
    else $error("supply control low bits not zero");

  a_status_live: assert property (@(posedge mclk) disable iff (rst)
    supplyRead |=> sfrRdata[`RSC_BIT_STATUS] == $past(supplyAbove))
    else $error("status bit not live monitor output");

  a_pin_flag_set: assert property (@(posedge mclk) disable iff (rst)
    (!running && !anySrc && pending[`RSC_BIT_PIN]) |=> flags[`RSC_BIT_PIN] && !sysReset)
    else $error("pin flag missing after pin reset");

  a_pin_not_driven: assert property (@(posedge mclk) disable iff (rst)
    (sysReset && !pending[`RSC_BIT_POR]) |-> rstPinOeN)
    else $error("reset pin driven by internal reset");

  a_comp_resets: assert property (@(posedge mclk) disable iff (rst)
    (running && compEnable && !compAbove) |=> sysReset)
    else $error("comparator reset not taken");

  a_soft_forces: assert property (@(posedge mclk) disable iff (rst)
    softSrc |=> sysReset ##0 pending[`RSC_BIT_SOFT])
    else $error("soft reset not forced");

  a_flash_guard: assert property (@(posedge mclk) disable iff (rst)
    (running && flashWriteErase && !flashGuarded) |=> sysReset && pending[`RSC_BIT_FLASH])
    else $error("unguarded flash write not faulted");

  a_level_cleared: assert property (@(posedge mclk) disable iff (rst)
    $rose(sysReset) |-> !level && !thresholdHigh)
    else $error("threshold select not cleared by reset");

  a_release_sync: assert property (@(posedge mclk) disable iff (rst)
    (!running && !anySrc) |=> !sysReset ##1 !sysReset || $past(anySrc))
    else $error("reset not released when sources idle");

  a_wdt_flag: assert property (@(posedge mclk) disable iff (rst)
    $fell(sysReset) |-> flags[`RSC_BIT_WDT] == $past(pending[`RSC_BIT_WDT]))
    else $error("watchdog flag does not match cause");

  a_monen_kept: assert property (@(posedge mclk) disable iff (rst)
    !supplyWrite |=> $stable(monEnable))
    else $error("monitor enable changed without write");
endmodule : reset_source_control
`default_nettype wire

// File: rsc_far_model.sv
// far-side model: reset pin circuit, supply monitor, comparator, clock-loss one-shot
`timescale 1ns/10ps
`default_nettype none
module rsc_far_model
(
  input  wire logic pinHold,     // outside circuit pulls pin low
  input  wire logic supplyLow,   // supply at or below threshold
  input  wire logic compLow,     // plus input below minus input
  input  wire logic stuck,       // one-shot has timed out
  input  wire logic rstPinOut,   // device pin value
  input  wire logic rstPinOeN,   // device enable, low drives
  output var  logic rstPinIn,    // resolved pin level
  output var  logic supplyAbove, // monitor output
  output var  logic compAbove,   // comparator output
  output var  logic clkStuck     // one-shot output
);
  assign rstPinIn = !(pinHold || (!rstPinOeN && !rstPinOut));
  assign supplyAbove = !supplyLow;
  assign compAbove = !compLow;
  assign clkStuck = stuck;
endmodule : rsc_far_model
`default_nettype wire

// File: reset_source_control_test.sv
// self-checking testbench for the reset source control block
`timescale 1ns/10ps
`default_nettype none
module reset_source_control_test
  import rsc_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, sfrWe = 1'b0, sfrRe = 1'b0, wdKick = 1'b0, kickOn = 1'b1;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, rd;
  logic pinHold = 1'b0, supplyLow = 1'b0, compLow = 1'b0, stuck = 1'b0, wdRunN = 1'b1;
  logic fWe = 1'b0, fCr = 1'b0, fBr = 1'b0, fSec = 1'b0;
  logic [15:0] fAddr = 16'h0000;
  wire logic [7:0] sfrRdata;
  wire logic rstPinIn, rstPinOut, rstPinOeN, supplyAbove, monitorOn, thresholdHigh;
  wire logic clkStuck, compAbove, sysReset;
  int errors = 0, checksDone = 0, kickCnt = 0;
  always #4 mclk = ~mclk;
  reset_source_control i_reset_source_control (.mclk(mclk), .rst(rst), .sfrAddr(sfrAddr),
    .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .rstPinIn(rstPinIn), .rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN),
    .supplyAbove(supplyAbove), .monitorOn(monitorOn), .thresholdHigh(thresholdHigh),
    .clkStuck(clkStuck), .compAbove(compAbove), .wdKick(wdKick), .wdRunN(wdRunN),
    .flashWriteErase(fWe), .flashCodeRead(fCr), .flashBranch(fBr), .flashAddr(fAddr),
    .flashSecBlocked(fSec), .sysReset(sysReset));
  rsc_far_model i_rsc_far_model (.pinHold(pinHold), .supplyLow(supplyLow), .compLow(compLow),
    .stuck(stuck), .rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN), .rstPinIn(rstPinIn),
    .supplyAbove(supplyAbove), .compAbove(compAbove), .clkStuck(clkStuck));
  // service pulses keep the watchdog quiet unless a test stops them
  always @(posedge mclk)
  begin
    kickCnt <= kickCnt + 1;
    wdKick <= kickOn && (kickCnt % 200 == 0);
  end
  //----------------------------------------
  // tasks
  //----------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask : cmp1
  task automatic sfrWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWe <= 1'b1;
    @(posedge mclk);
    sfrWe <= 1'b0;
  endtask : sfrWrite
  task automatic sfrRead(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    sfrAddr <= a;
    sfrRe <= 1'b1;
    @(posedge mclk);
    sfrRe <= 1'b0;
    #1 d = sfrRdata;
  endtask : sfrRead
  task automatic noReset(input int n);
    repeat (n) @(posedge mclk) #1 cmp1(sysReset, 1'b0);
  endtask : noReset
  task automatic flashPulse(input logic [2:0] kind, input logic [15:0] a, input logic sec);
    @(posedge mclk);
    {fWe, fCr, fBr} <= kind;
    fAddr <= a;
    fSec <= sec;
    @(posedge mclk);
    {fWe, fCr, fBr, fSec} <= 4'h0;
  endtask : flashPulse
  // waits for a reset, checks pin drive, clears stimuli, checks the cause flags
  task automatic expectReset(input logic [7:0] exp, input logic drive, input int maxWait);
    int i;
    logic seen;
    #1 seen = (sysReset === 1'b1);
    for (i = 0; i < maxWait && !seen; i++)
      @(posedge mclk) #1 seen = (sysReset === 1'b1);
    if (!seen)
    begin
      errors++;
      wrap_up();
    end
    repeat (2) @(posedge mclk) #1 cmp1(rstPinOeN, !drive);
    cmp1(rstPinOut, 1'b0);
    @(posedge mclk);
    {pinHold, supplyLow, compLow, stuck} <= 4'h0;
    for (i = 0; i < 50 && sysReset !== 1'b0; i++)
      @(posedge mclk) #1;
    if (sysReset !== 1'b0)
    begin
      errors++;
      wrap_up();
    end
    sfrRead(8'hEF, rd);
    cmp8(rd, exp);
  endtask : expectReset
  task automatic armFlash();
    sfrWrite(8'hFF, 8'hA0);
    repeat (20) @(posedge mclk);
    sfrWrite(8'hEF, 8'h02);
    #1 cmp1(thresholdHigh, 1'b1);
  endtask : armFlash
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 20 && sysReset !== 1'b0; i++)
      @(posedge mclk) #1;
    cmp1(sysReset, 1'b0);
    sfrRead(8'hFF, rd);
    cmp8(rd, 8'hC0);
    sfrRead(8'hEF, rd);
    cmp8(rd, 8'h02);
    sfrRead(8'h10, rd);
    cmp8(rd, 8'h00);
    $display("test power-on done");
    sfrWrite(8'hFF, 8'h3F);
    sfrRead(8'hFF, rd);
    cmp8(rd, 8'h60);
    supplyLow <= 1'b1;
    sfrRead(8'hFF, rd);
    cmp8(rd, 8'h20);
    cmp1(monitorOn, 1'b0);
    supplyLow <= 1'b0;
    stuck <= 1'b1;
    noReset(5);
    stuck <= 1'b0;
    sfrWrite(8'hEF, 8'h04);
    stuck <= 1'b1;
    expectReset(8'h04, 1'b0, 10);
    $display("test monitor and clock-loss done");
    sfrWrite(8'hEF, 8'h10);
    expectReset(8'h10, 1'b0, 10);
    sfrRead(8'hFF, rd);
    cmp8(rd, 8'h40);
    pinHold <= 1'b1;
    expectReset(8'h01, 1'b0, 10);
    sfrWrite(8'hEF, 8'h20);
    compLow <= 1'b1;
    expectReset(8'h20, 1'b0, 10);
    $display("test soft, pin and comparator done");
    flashPulse(3'b100, 16'h0100, 1'b0);
    expectReset(8'h40, 1'b0, 10);
    armFlash();
    flashPulse(3'b010, 16'h0100, 1'b0);
    noReset(5);
    flashPulse(3'b010, 16'h0100, 1'b1);
    expectReset(8'h40, 1'b0, 10);
    armFlash();
    flashPulse(3'b001, 16'hF800, 1'b0);
    expectReset(8'h40, 1'b0, 10);
    supplyLow <= 1'b1;
    expectReset(8'h02, 1'b1, 10);
    $display("test flash and supply done");
    kickOn <= 1'b0;
    expectReset(8'h08, 1'b0, 4000);
    wdRunN <= 1'b0;
    noReset(3200);
    $display("test watchdog done");
    wrap_up();
  end
endmodule : reset_source_control_test
`default_nettype wire
